// ### hw/dmn_exec.sv
// How it works
// RL1 - Float multiply of two sources goes to an ext register.
// RL2 - Integer multiply by destination, 24-bit signed, low 32 bits kept.
// RL3 - Three-operand integer multiply of 24-bit sources, low 32 bits kept.
// RL4 - Negate with borrow gives zero minus source minus carry.
// RL5 - Float negate writes zero minus source to ext register, or in place.
// RL6 - Integer negate writes zero minus source to destination, or in place.
// RL7 - Idle runs no unit; only an indirect operand's address update happens.
// RL8 - Leading bit align normalizes a float source into an ext register.
// RL9 - Complement inverts the low 32 source bits into destination, or in place.
// RL10 - Ext-register results accept only destinations zero to seven.
// RL11 - Indirect addressing picks one of eight address registers to update.
// RL12 - Carry sampled at start; only the destination and an indirect operand's address register change.
`timescale 1ns/1ps
`default_nettype none
module dmn_exec
(
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic START,
    input wire dmn_pkg::dmn_op_t OPCODE,
    input wire logic ONE_OPERAND,
    input wire logic OPERAND_GIVEN,
    input wire logic [dmn_pkg::EXT_W-1:0] FIRST_SOURCE_OPERAND,
    input wire logic [dmn_pkg::EXT_W-1:0] SECOND_SOURCE_OPERAND,
    input wire logic [dmn_pkg::EXT_W-1:0] DST_IN,
    input wire logic [dmn_pkg::REG_SEL_W-1:0] DST_SEL,
    input wire logic CARRY_IN,
    input wire logic SRC_INDIRECT,
    input wire logic [dmn_pkg::AR_SEL_W-1:0] AR_SEL,
    input wire logic [dmn_pkg::WORD_W-1:0] AR_NEXT,
    output logic [dmn_pkg::EXT_W-1:0] RESULT,
    output logic [dmn_pkg::REG_SEL_W-1:0] RESULT_DST,
    output logic RESULT_WE,
    output logic AR_WE,
    output logic [dmn_pkg::AR_SEL_W-1:0] AR_INDEX,
    output logic [dmn_pkg::WORD_W-1:0] AR_VALUE,
    output logic ILLEGAL
);
    import dmn_pkg::*;

    logic rst_meta_r;
    logic rst_sync_r;
    logic rst_n;

    ////////////////////////////////////////////////////////////////////
    // Reset release through two flip-flops
    always_ff @(posedge CLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end
        else
        begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end
    assign rst_n = rst_sync_r;

    ////////////////////////////////////////////////////////////////////
    // Operand selection and unit steering
    logic [EXT_W-1:0] src;
    logic ext_dst;
    logic int_op;
    logic dst_ok;
    logic idle_ok;
    logic legal;
    dmn_fop_t fop;
    dmn_iop_t iop;
    logic [WORD_W-1:0] int_a;
    logic [WORD_W-1:0] int_b;
    logic [WORD_W-1:0] int_y;
    logic [EXT_W-1:0] flt_b;
    logic [EXT_W-1:0] flt_y;

    // One-operand forms take the destination as their source
    assign src = ONE_OPERAND ? DST_IN : FIRST_SOURCE_OPERAND;

    always_comb
    begin
        ext_dst = 1'b0;
        int_op = 1'b0;
        fop = FOP_ALIGN;
        iop = IOP_NOT;
        int_a = src[WORD_W-1:0];
        int_b = DST_IN[WORD_W-1:0];
        flt_b = SECOND_SOURCE_OPERAND;
        case (OPCODE)
            float_multiply_three_operand:
            begin
                ext_dst = 1'b1;
                fop = FOP_MUL;                       // [RL1]
            end
            integer_multiply_two_operand:
            begin
                int_op = 1'b1;
                iop = IOP_MUL;                       // [RL2]
            end
            integer_multiply_three_operand:
            begin
                int_op = 1'b1;
                iop = IOP_MUL;
                int_b = SECOND_SOURCE_OPERAND[WORD_W-1:0]; // [RL3]
            end
            integer_negate_with_borrow:
            begin
                int_op = 1'b1;
                iop = IOP_NEG_BORROW;                // [RL4]
            end
            float_negate:
            begin
                ext_dst = 1'b1;
                fop = FOP_NEG;                       // [RL5]
            end
            integer_negate:
            begin
                int_op = 1'b1;
                iop = IOP_NEG;                       // [RL6]
            end
            float_leading_bit_align:
            begin
                ext_dst = 1'b1;
                fop = FOP_ALIGN;                     // [RL8]
            end
            bitwise_complement:
            begin
                int_op = 1'b1;
                iop = IOP_NOT;                       // [RL9]
            end
            default:
            begin
                ext_dst = 1'b0;                      // Idle: no unit [RL7]
                int_op = 1'b0;
            end
        endcase
    end

    // Destination and operand legality checks
    assign dst_ok = !ext_dst || (DST_SEL < EXT_REG_COUNT);       // [RL10]
    assign idle_ok = (OPCODE != idle_operation) || !OPERAND_GIVEN ||
                     SRC_INDIRECT;                               // [RL7]
    assign legal = dst_ok && idle_ok;

    dmn_int_unit u_int
    (
        .op(iop),
        .a(int_a),
        .b(int_b),
        .borrow(CARRY_IN),                           // Sampled at start [RL12]
        .y(int_y)
    );

    dmn_float_unit u_flt
    (
        .op(fop),
        .a(src),
        .b(flt_b),
        .y(flt_y)
    );

    ////////////////////////////////////////////////////////////////////
    // Result and address register write-back
    logic [EXT_W-1:0] result_r;
    logic [EXT_W-1:0] result_nxt;
    logic [REG_SEL_W-1:0] dst_r;
    logic [REG_SEL_W-1:0] dst_nxt;
    logic we_r;
    logic we_nxt;
    logic ar_we_r;
    logic ar_we_nxt;
    logic [AR_SEL_W-1:0] ar_idx_r;
    logic [AR_SEL_W-1:0] ar_idx_nxt;
    logic [WORD_W-1:0] ar_val_r;
    logic [WORD_W-1:0] ar_val_nxt;
    logic ill_r;
    logic ill_nxt;

    always_comb
    begin
        result_nxt = result_r;
        dst_nxt = dst_r;
        ar_idx_nxt = ar_idx_r;
        ar_val_nxt = ar_val_r;
        we_nxt = 1'b0;
        ar_we_nxt = 1'b0;
        ill_nxt = 1'b0;
        if (START)
        begin
            ill_nxt = !legal;
            if (legal && (int_op || ext_dst))
            begin
                we_nxt = 1'b1;                       // Only the destination [RL12]
                dst_nxt = DST_SEL;
                // Integer results keep the exponent field of the target
                result_nxt = int_op ? {DST_IN[EXP_MSB:EXP_LSB], int_y}
                                    : flt_y;
            end
            if (legal && SRC_INDIRECT && OPERAND_GIVEN)
            begin
                ar_we_nxt = 1'b1;                    // [RL11] [RL7]
                ar_idx_nxt = AR_SEL;
                ar_val_nxt = AR_NEXT;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n)
    begin
        if (!rst_n)
        begin
            result_r <= RESULT_RST;
            dst_r <= DST_RST;
            we_r <= 1'b0;
            ar_we_r <= 1'b0;
            ar_idx_r <= AR_SEL_RST;
            ar_val_r <= AR_VAL_RST;
            ill_r <= 1'b0;
        end
        else
        begin
            result_r <= result_nxt;
            dst_r <= dst_nxt;
            we_r <= we_nxt;
            ar_we_r <= ar_we_nxt;
            ar_idx_r <= ar_idx_nxt;
            ar_val_r <= ar_val_nxt;
            ill_r <= ill_nxt;
        end
    end

    assign RESULT = result_r;
    assign RESULT_DST = dst_r;
    assign RESULT_WE = we_r;
    assign AR_WE = ar_we_r;
    assign AR_INDEX = ar_idx_r;
    assign AR_VALUE = ar_val_r;
    assign ILLEGAL = ill_r;

    ////////////////////////////////////////////////////////////////////
    // Checks on the write-back
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    logic signed [2*INT_MPY_W-1:0] ref_prod;
    logic signed [2*INT_MPY_W-1:0] ref_prod2;
    logic [WORD_W-1:0] ref_low;
    logic [WORD_W-1:0] ref_low2;

    // Full-width reference products of the 24-bit fields, kept as signals
    assign ref_prod = $signed(src[INT_MPY_W-1:0]) *
                      $signed(SECOND_SOURCE_OPERAND[INT_MPY_W-1:0]);
    assign ref_prod2 = $signed(src[INT_MPY_W-1:0]) *
                       $signed(DST_IN[INT_MPY_W-1:0]);
    assign ref_low = ref_prod[WORD_W-1:0];
    assign ref_low2 = ref_prod2[WORD_W-1:0];

    a_int_mpy3_low: assert property ( // [RL3]
        START && OPCODE == integer_multiply_three_operand && !ONE_OPERAND
        |=> RESULT_WE && RESULT[31:0] == $past(ref_low))
        else $error("three-operand multiply low word wrong");

    a_int_mpy2_low: assert property ( // [RL2]
        START && OPCODE == integer_multiply_two_operand
        |=> RESULT[31:0] == $past(ref_low2))
        else $error("two-operand multiply low word wrong");

    a_borrow_value: assert property ( // [RL4]
        START && OPCODE == integer_negate_with_borrow
        |=> RESULT[31:0] == 32'(32'h0 - $past(int_a) -
                                 {31'h0, $past(CARRY_IN)}))
        else $error("negate with borrow wrong");

    a_neg_value: assert property ( // [RL6]
        START && OPCODE == integer_negate
        |=> RESULT[31:0] + $past(int_a) == 32'h0)
        else $error("integer negate wrong");

    a_not_value: assert property ( // [RL9]
        START && OPCODE == bitwise_complement
        |=> (RESULT[31:0] ^ $past(int_a)) == 32'hffff_ffff)
        else $error("complement wrong");

    a_idle_no_write: assert property ( // [RL7]
        START && OPCODE == idle_operation |=> !RESULT_WE)
        else $error("idle operation wrote a result");

    a_ext_dst_range: assert property ( // [RL10]
        START && ext_dst && DST_SEL >= EXT_REG_COUNT
        |=> ILLEGAL && !RESULT_WE && !AR_WE)
        else $error("bad ext destination accepted");

    // Back-to-back refusals are legal, so the pulse is tied to its start
    a_ill_after_start: assert property ( // [RL7]
        ILLEGAL |-> $past(START))
        else $error("refusal pulse without an instruction");

    a_ar_update: assert property ( // [RL11]
        START && legal && SRC_INDIRECT && OPERAND_GIVEN
        |=> AR_WE && AR_INDEX == $past(AR_SEL) &&
            AR_VALUE == $past(AR_NEXT))
        else $error("address register update wrong");

    a_float_form: assert property ( // [RL8]
        START && legal && ext_dst
        |=> RESULT[EXP_MSB:EXP_LSB] == EXP_ZERO || RESULT[31] != RESULT[30])
        else $error("float result not normalized");

    a_dst_only: assert property ( // [RL12]
        RESULT_WE |-> RESULT_DST == $past(DST_SEL) && $past(START))
        else $error("write to other than destination");

    c_float_mul: cover property (
        START && OPCODE == float_multiply_three_operand && legal ##1 RESULT_WE);
    c_borrow_carry: cover property (
        START && OPCODE == integer_negate_with_borrow && CARRY_IN);
    c_idle_ar: cover property (
        START && OPCODE == idle_operation && SRC_INDIRECT ##1 AR_WE);
    c_illegal: cover property (ILLEGAL);
endmodule // dmn_exec
`default_nettype wire

// ### shared/dmn_pkg.sv
`default_nettype none
package dmn_pkg;
    // Data widths of the datapath
    localparam int WORD_W = 32;
    localparam int EXP_W = 8;
    localparam int EXT_W = 40;
    localparam int INT_MPY_W = 24;
    localparam int REG_SEL_W = 5;
    localparam int AR_SEL_W = 3;
    // Field positions of an extended-precision word
    localparam int EXP_LSB = 32;
    localparam int EXP_MSB = 39;
    localparam int MAN_MSB = 31;
    // Extended-precision destinations are numbered 0 to 7
    localparam logic [REG_SEL_W-1:0] EXT_REG_COUNT = 5'h08;
    // Exponent that marks a floating-point zero, and the limits
    localparam logic [EXP_W-1:0] EXP_ZERO = 8'h80;
    localparam int EXP_MAX = 127;
    localparam int EXP_MIN = -127;
    // Values after reset
    localparam logic [EXT_W-1:0] RESULT_RST = 40'h00_0000_0000;
    localparam logic [REG_SEL_W-1:0] DST_RST = 5'h00;
    localparam logic [AR_SEL_W-1:0] AR_SEL_RST = 3'h0;
    localparam logic [WORD_W-1:0] AR_VAL_RST = 32'h0000_0000;
    // Cycles from an accepted start to the result strobe
    localparam int RESULT_LATENCY = 1;

    // Instruction group handled by the slice
    typedef enum logic [3:0] {
        float_multiply_three_operand,
        integer_multiply_two_operand,
        integer_multiply_three_operand,
        integer_negate_with_borrow,
        float_negate,
        integer_negate,
        idle_operation,
        float_leading_bit_align,
        bitwise_complement
    } dmn_op_t;

    // Sub-operations of the floating-point unit
    typedef enum logic [1:0] {
        FOP_MUL,
        FOP_NEG,
        FOP_ALIGN
    } dmn_fop_t;

    // Sub-operations of the integer unit
    typedef enum logic [1:0] {
        IOP_MUL,
        IOP_NEG,
        IOP_NEG_BORROW,
        IOP_NOT
    } dmn_iop_t;
endpackage
`default_nettype wire

// ### hw/dmn_int_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dmn_int_unit
(
    input wire dmn_pkg::dmn_iop_t op,
    input wire logic [dmn_pkg::WORD_W-1:0] a,
    input wire logic [dmn_pkg::WORD_W-1:0] b,
    input wire logic borrow,
    output logic [dmn_pkg::WORD_W-1:0] y
);
    import dmn_pkg::*;

    logic signed [2*INT_MPY_W-1:0] prod;

    ////////////////////////////////////////////////////////////////////
    // Signed 24 x 24 product of the low fields
    assign prod = $signed(a[INT_MPY_W-1:0]) * $signed(b[INT_MPY_W-1:0]);

    ////////////////////////////////////////////////////////////////////
    // Result select; a is the source operand
    always_comb
    begin
        case (op)
            IOP_MUL:  y = prod[WORD_W-1:0];          // Low 32 bits only
            IOP_NEG:  y = WORD_W'(32'h0 - a);
            IOP_NEG_BORROW: y = WORD_W'(32'h0 - a - {31'h0, borrow});
            IOP_NOT:  y = ~a;
            default:  y = '0;
        endcase
    end
endmodule // dmn_int_unit
`default_nettype wire

// ### hw/dmn_float_unit.sv
`timescale 1ns/1ps
`default_nettype none
module dmn_float_unit
(
    input wire dmn_pkg::dmn_fop_t op,
    input wire logic [dmn_pkg::EXT_W-1:0] a,
    input wire logic [dmn_pkg::EXT_W-1:0] b,
    output logic [dmn_pkg::EXT_W-1:0] y
);
    import dmn_pkg::*;

    logic signed [EXP_W-1:0] ea;
    logic signed [EXP_W-1:0] eb;
    logic signed [WORD_W-1:0] ma;
    logic signed [WORD_W-1:0] mb;
    logic signed [2*WORD_W-1:0] prod;
    logic [WORD_W:0] raw;
    logic [WORD_W:0] shifted;
    logic signed [9:0] exp_in;
    logic signed [9:0] exp_out;
    logic [5:0] lead;
    logic is_zero;
    logic [WORD_W-1:0] differs;

    assign ea = a[EXP_MSB:EXP_LSB];
    assign eb = b[EXP_MSB:EXP_LSB];
    assign ma = a[MAN_MSB:0];
    assign mb = b[MAN_MSB:0];
    assign prod = ma * mb;

    ////////////////////////////////////////////////////////////////////
    // Raw 33-bit mantissa (value raw / 2^30) and its exponent
    always_comb
    begin
        case (op)
            FOP_MUL:
            begin
                raw = prod[62:30];
                exp_in = 10'(ea) + 10'(eb);
            end
            FOP_NEG:
            begin
                raw = 33'h0 - {ma[MAN_MSB], ma};
                exp_in = 10'(ea);
            end
            default:
            begin
                raw = {ma[MAN_MSB], ma};
                exp_in = 10'(ea);
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Bits that differ from the sign, one per position
    genvar gi;
    generate
        for (gi = 0; gi < WORD_W; gi++)
        begin : g_diff
            assign differs[gi] = raw[gi] ^ raw[WORD_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Count redundant sign bits and align the leading bit
    always_comb
    begin
        lead = 6'h20;
        for (int i = 0; i < WORD_W; i++)
        begin
            if (differs[i])
            begin
                lead = 6'(WORD_W - 1 - i);
            end
        end
        shifted = raw << lead;
        exp_out = exp_in + 10'sh001 - 10'(lead);
        is_zero = (raw == '0) ||
                  (op == FOP_MUL && (ea == EXP_ZERO || eb == EXP_ZERO)) ||
                  (op != FOP_MUL && ea == EXP_ZERO);
        if (is_zero || exp_out < 10'(EXP_MIN))
        begin
            y = {EXP_ZERO, 32'h0};                   // Zero or underflow
        end
        else if (exp_out > 10'(EXP_MAX))
        begin
            y = {8'h7f, shifted[WORD_W:1]};          // Exponent clamped
        end
        else
        begin
            y = {exp_out[EXP_W-1:0], shifted[WORD_W:1]};
        end
    end
endmodule // dmn_float_unit
`default_nettype wire

// ### verif/dmn_exec_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dmn_exec_tb;
    import dmn_pkg::*;
    logic clk, rst_n, start, one_op, given, carry_in, src_ind;
    dmn_op_t opcode;
    logic [EXT_W-1:0] first_source_operand, second_source_operand;
    logic [EXT_W-1:0] dst_in, result;
    logic [REG_SEL_W-1:0] dst_sel, result_dst;
    logic [AR_SEL_W-1:0] ar_sel, ar_index;
    logic [WORD_W-1:0] ar_next, ar_value;
    logic result_we, ar_we, illegal;
    int fails = 0;
    int n_checks = 0;

    dmn_exec u_dmn_exec (.CLK(clk), .RST_N(rst_n), .START(start),
        .OPCODE(opcode), .ONE_OPERAND(one_op), .OPERAND_GIVEN(given),
        .FIRST_SOURCE_OPERAND(first_source_operand),
        .SECOND_SOURCE_OPERAND(second_source_operand),
        .DST_IN(dst_in), .DST_SEL(dst_sel),
        .CARRY_IN(carry_in), .SRC_INDIRECT(src_ind), .AR_SEL(ar_sel),
        .AR_NEXT(ar_next), .RESULT(result), .RESULT_DST(result_dst),
        .RESULT_WE(result_we), .AR_WE(ar_we), .AR_INDEX(ar_index),
        .AR_VALUE(ar_value), .ILLEGAL(illegal));

    // Free-running 125 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Compare and drive helpers
    task automatic cmp_val(input string what, input logic [39:0] exp,
                           input logic [39:0] got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic cmp_flag(input string what, input logic exp,
                            input logic got);
        n_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask

    // Waits for the next falling edge, then presents one instruction with
    // START high, so START is never written twice in one time step
    task automatic issue(input dmn_op_t op, input logic one, input logic gv,
                         input logic ind, input logic cin,
                         input logic [39:0] a, input logic [39:0] b,
                         input logic [39:0] d, input logic [4:0] sel);
        @(negedge clk);
        opcode = op;
        one_op = one;
        given = gv;
        src_ind = ind;
        carry_in = cin;
        first_source_operand = a;
        second_source_operand = b;
        dst_in = d;
        dst_sel = sel;
        start = 1'b1;
    endtask

    // Lets the taking edge pass, then drops START
    task automatic answer();
        @(negedge clk);
        start = 1'b0;
    endtask

    // Outputs seen half a cycle after the taking edge
    task automatic expect_out(input logic we, input logic awe,
                              input logic ill);
        cmp_flag("result_we", we, result_we);
        cmp_flag("ar_we", awe, ar_we);
        cmp_flag("illegal", ill, illegal);
    endtask

    task automatic expect_res(input logic [39:0] v, input logic [4:0] sel);
        expect_out(1'b1, 1'b0, 1'b0);
        cmp_val("result", v, result);
        cmp_val("result_dst", 40'(sel), 40'(result_dst));
    endtask

    // Low 32 bits of the signed product of two 24-bit fields
    function automatic logic [31:0] mul24(input logic [39:0] a,
                                          input logic [39:0] b);
        logic signed [47:0] p;
        p = $signed(a[23:0]) * $signed(b[23:0]);
        return p[31:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_int_ops();
        logic [39:0] a, b;
        a = 40'h00_12ff_fffe;
        b = 40'hcd_ab00_0003;
        issue(integer_negate, 0, 1, 0, 0, 40'h5, 0, 40'hab_0000_0000, 5'h03);
        answer();
        expect_res(40'hab_ffff_fffb, 5'h03);
        issue(integer_negate, 1, 1, 0, 0, 40'h5, 0, 40'h12_8000_0000, 5'h1f);
        answer();
        expect_res(40'h12_8000_0000, 5'h1f);
        issue(integer_multiply_two_operand, 0, 1, 0, 0, a, 0, b, 5'h04);
        answer();
        expect_res({8'hcd, mul24(a, b)}, 5'h04);
        a = 40'h00_0080_0000;
        b = 40'h00_777f_ffff;
        issue(integer_multiply_three_operand, 0, 1, 0, 0, a, b,
              40'h3c_0000_0000, 5'h09);
        answer();
        expect_res({8'h3c, mul24(a, b)}, 5'h09);
        issue(bitwise_complement, 0, 1, 0, 0, 40'ha5a5_0f0f, 0, 0, 5'h02);
        answer();
        expect_res(40'h00_5a5a_f0f0, 5'h02);
        issue(bitwise_complement, 1, 1, 0, 0, 0, 0, 40'h77_0000_ffff, 5'h11);
        answer();
        expect_res(40'h77_ffff_0000, 5'h11);
    endtask

    task automatic t_borrow();
        issue(integer_negate_with_borrow, 0, 1, 0, 1, 40'h5, 0, 0, 5'h06);
        answer();
        expect_res(40'h00_ffff_fffa, 5'h06);
        issue(integer_negate_with_borrow, 0, 1, 0, 0, 40'h5, 0, 0, 5'h06);
        answer();
        expect_res(40'h00_ffff_fffb, 5'h06);
        issue(integer_negate_with_borrow, 1, 1, 0, 1, 40'h9, 0, 0, 5'h07);
        answer();
        expect_res(40'h00_ffff_ffff, 5'h07);
    endtask

    task automatic t_float();
        issue(float_multiply_three_operand, 0, 1, 0, 0, 40'h00_6000_0000,
              40'h01_4000_0000, 0, 5'h07);
        answer();
        expect_res(40'h01_6000_0000, 5'h07);
        issue(float_negate, 0, 1, 0, 0, 40'h00_6000_0000, 0, 0, 5'h01);
        answer();
        expect_res(40'h00_a000_0000, 5'h01);
        issue(float_negate, 1, 1, 0, 0, 0, 0, 40'h80_0000_0000, 5'h00);
        answer();
        expect_res(40'h80_0000_0000, 5'h00);
        issue(float_leading_bit_align, 0, 1, 0, 0, 40'h00_2000_0000, 0, 0,
              5'h05);
        answer();
        expect_res(40'hff_4000_0000, 5'h05);
        issue(float_leading_bit_align, 1, 1, 0, 0, 0, 0, 40'h03_1000_0000,
              5'h02);
        answer();
        expect_res(40'h01_4000_0000, 5'h02);
    endtask

    // Extended-precision results refused above register seven
    task automatic t_refuse();
        dmn_op_t ops [3];
        ops = '{float_multiply_three_operand, float_negate,
                float_leading_bit_align};
        foreach (ops[i])
        begin
            issue(ops[i], 0, 1, 0, 0, 40'h00_4000_0000, 40'h00_4000_0000,
                  0, 5'h08 + 5'(i));
            answer();
            expect_out(1'b0, 1'b0, 1'b1);
            cmp_val("result_hold", 40'h01_4000_0000, result);
        end
    endtask

    task automatic t_idle();
        ar_sel = 3'h7;
        ar_next = 32'h0000_1234;
        issue(idle_operation, 0, 1, 1, 0, 0, 0, 0, 5'h03);
        answer();
        expect_out(1'b0, 1'b1, 1'b0);
        cmp_val("ar_index", 40'h7, 40'(ar_index));
        cmp_val("ar_value", 40'h1234, 40'(ar_value));
        issue(idle_operation, 0, 0, 0, 0, 0, 0, 0, 5'h03);
        answer();
        expect_out(1'b0, 1'b0, 1'b0);
        issue(idle_operation, 0, 1, 0, 0, 0, 0, 0, 5'h03);
        answer();
        expect_out(1'b0, 1'b0, 1'b1);
        cmp_val("ar_value_hold", 40'h1234, 40'(ar_value));
        ar_sel = 3'h0;
        ar_next = 32'hfedc_0000;
        issue(integer_negate, 0, 1, 1, 0, 40'h1, 0, 0, 5'h0a);
        answer();
        cmp_flag("ar_we", 1'b1, ar_we);
        cmp_val("ar_index", 40'h0, 40'(ar_index));
        cmp_val("ar_value", 40'hfedc_0000, 40'(ar_value));
        cmp_val("result", 40'h00_ffff_ffff, result);
    endtask

    // Two instructions on consecutive edges
    task automatic t_back_to_back();
        issue(integer_negate, 0, 1, 0, 0, 40'h2, 0, 0, 5'h0c);
        issue(bitwise_complement, 0, 1, 0, 0, 40'h0, 0, 0, 5'h0d);
        expect_res(40'h00_ffff_fffe, 5'h0c);
        answer();
        expect_res(40'h00_ffff_ffff, 5'h0d);
        @(negedge clk);
        expect_out(1'b0, 1'b0, 1'b0);
    endtask

    // Mid-run reset clears the outputs; a start after release is taken
    task automatic t_reset();
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        cmp_val("result_mid_rst", RESULT_RST, result);
        cmp_val("dst_mid_rst", 40'(DST_RST), 40'(result_dst));
        cmp_val("ar_mid_rst", 40'(AR_VAL_RST), 40'(ar_value));
        expect_out(1'b0, 1'b0, 1'b0);
        rst_n = 1'b1;
        repeat (2) @(negedge clk);
        issue(integer_negate, 0, 1, 0, 0, 40'h7, 0, 0, 5'h04);
        answer();
        expect_res(40'h00_ffff_fff9, 5'h04);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        rst_n = 1'b0;
        start = 1'b0;
        opcode = idle_operation;
        {one_op, given, carry_in, src_ind} = 4'h0;
        {first_source_operand, second_source_operand, dst_in} = '0;
        dst_sel = 5'h00;
        ar_sel = 3'h0;
        ar_next = 32'h0000_0000;
        repeat (20) @(negedge clk);
        cmp_val("result_rst", RESULT_RST, result);
        cmp_val("ar_value_rst", 40'(AR_VAL_RST), 40'(ar_value));
        expect_out(1'b0, 1'b0, 1'b0);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_int_ops();
        t_borrow();
        t_float();
        t_refuse();
        t_idle();
        t_back_to_back();
        t_reset();
        print_verdict();
    end
endmodule // dmn_exec_tb
`default_nettype wire
